// ==== design/bst_pkg.sv ====
// Shared constants and types for the boundary scan test access port.
package bst_pkg;

	localparam int unsigned IR_W     = 3;         // Instruction register width
	localparam int unsigned ID_W     = 32;        // Identification register width
	localparam int unsigned BSR_W    = 129;       // Boundary register length
	localparam int unsigned RING_W   = BSR_W - 1; // I/O ring cells, bits 0 to 127
	localparam int unsigned INT_CELL = BSR_W - 1; // Internal cell index (bit 128)

	// Instruction codes
	localparam logic [IR_W-1:0] INS_EXT_TEST  = 3'h0; // Drive output cells to pins
	localparam logic [IR_W-1:0] INS_ID_READ   = 3'h1; // Identification register
	localparam logic [IR_W-1:0] INS_SAMPLE_Z  = 3'h2; // Sample with drivers off
	localparam logic [IR_W-1:0] INS_SAMPLE    = 3'h4; // Sample, pins untouched
	localparam logic [IR_W-1:0] INS_BYPASS    = 3'h7; // One-bit bypass

	// Reset and capture values
	localparam logic [IR_W-1:0] IR_RESET_VAL  = INS_ID_READ; // Instruction after reset
	localparam logic            BYP_CAPTURE   = 1'b0;        // Bypass capture value
	localparam logic            INT_CELL_CAP  = 1'b1;        // Internal cell capture value

	// Identification code; value is arbitrary, bit 0 must stay one
	localparam logic [ID_W-1:0] ID_DEFAULT    = 32'h0A5C_3E01;

	// Controller states
	typedef enum logic [3:0] {
		ST_RESET     = 4'h0,
		ST_IDLE      = 4'h1,
		ST_SEL_DR    = 4'h2,
		ST_CAP_DR    = 4'h3,
		ST_SHIFT_DR  = 4'h4,
		ST_EXIT1_DR  = 4'h5,
		ST_PAUSE_DR  = 4'h6,
		ST_EXIT2_DR  = 4'h7,
		ST_UPD_DR    = 4'h8,
		ST_SEL_IR    = 4'h9,
		ST_CAP_IR    = 4'hA,
		ST_SHIFT_IR  = 4'hB,
		ST_EXIT1_IR  = 4'hC,
		ST_PAUSE_IR  = 4'hD,
		ST_EXIT2_IR  = 4'hE,
		ST_UPD_IR    = 4'hF
	} bst_state_t;

endpackage

// ==== design/bst_sync.sv ====
// Two-stage synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
module bst_sync #(
	parameter int unsigned W = 1                // Number of bits
) (
	input  wire logic         clk,              // System clock
	input  wire logic         arst_n,           // Asynchronous reset, active low
	input  wire logic [W-1:0] d,                // Asynchronous input
	output logic      [W-1:0] q                 // Synchronised output
);

	typedef struct packed {
		logic [W-1:0] meta;                     // First stage, read by second only
		logic [W-1:0] stab;                     // Second stage
	} bst_sync_st_t;

	bst_sync_st_t st_ff;                        // Registered state
	bst_sync_st_t nxt_st;                       // Next state

	// Elaboration stops on a width the stages cannot hold
	if (W < 1)
	begin
		$error("bst_sync: width must be at least one");
	end

	// Shift the input through both stages
	always_comb
	begin
		nxt_st      = st_ff;
		nxt_st.meta = d;
		nxt_st.stab = st_ff.meta;
	end

	// State register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign q = st_ff.stab;

endmodule

// ==== design/bst_tap.sv ====
// Boundary scan test access port: controller, instruction and data registers.
`timescale 1ns/1ps
// Function
// - Sample mode-select and data on test-clock rise
// - Update serial output on test-clock fall
// - Memory untouched except external-test and sample-Z
// - Sixteen-state controller stepped by mode-select
// - Power-up or five ones reach reset state
// - Serial input taken only in shift states
// - Output driver enabled only in shift states
// - Shift on rise, present bit on fall
// - Instruction loads identify code on reset, capture
// - Shifted instruction takes effect at update
// - External test captures, shifts, drives output cells
// - Identify instruction captures and shifts fixed code
// - Sample-Z like external test, drivers off
// - Termination disabled under external-test or sample-Z
// - Bypass captures zero, shifts one bit
// - Sample leaves pins; reserved codes act bypass
// - Identify register 32 bits, bit0 one
// - Boundary 129 bits, internal cell gates drivers
module bst_tap
	import bst_pkg::*;
#(
	parameter logic [bst_pkg::ID_W-1:0] ID_VALUE = bst_pkg::ID_DEFAULT // Identification code
) (
	input  wire logic                        clk,         // System clock, 50 MHz
	input  wire logic                        arst_n,      // Asynchronous reset, active low
	input  wire logic                        tck,         // Test clock pin
	input  wire logic                        tms,         // Mode-select pin
	input  wire logic                        tdi,         // Serial data in pin
	output logic                             tdo,         // Serial data out
	output logic                             tdo_oe,      // Serial out driver enable
	input  wire logic [bst_pkg::RING_W-1:0]  ring_in,     // I/O ring levels to capture
	output logic      [bst_pkg::RING_W-1:0]  ring_out,    // Output cell values for pins
	output logic                             pins_takeover, // Test logic owns pins
	output logic                             q_drive_en,  // Read-data drivers enabled
	output logic                             on_die_termination_dis // Termination off
);

	import bst_pkg::*;

	typedef struct packed {
		bst_state_t        state;               // Controller state
		logic              tck_prev;            // Test clock at previous sample
		logic [IR_W-1:0]   ir_sh;               // Instruction shift stage
		logic [IR_W-1:0]   ir_cur;              // Instruction in effect
		logic [ID_W-1:0]   id_sh;               // Identification register
		logic              byp;                 // Bypass register
		logic [BSR_W-1:0]  bsr_sh;              // Boundary shift stage
		logic [BSR_W-1:0]  bsr_upd;             // Boundary update stage
		logic              tdo;                 // Serial output bit
		logic              tdo_oe;              // Serial output enable
		logic [2:0]        ones_cnt;            // Run of mode-select ones, saturating
	} bst_tap_st_t;

	bst_tap_st_t st_ff;                         // Registered state
	bst_tap_st_t nxt_st;                        // Next state

	logic [2:0]        pin_s;                   // Synchronised tck, tms, tdi
	logic [RING_W-1:0] ring_s;                  // Synchronised ring levels
	logic              tck_s;                   // Synchronised test clock
	logic              tms_s;                   // Synchronised mode-select
	logic              tdi_s;                   // Synchronised serial input
	logic              tck_rise;                // Rising test-clock edge seen
	logic              tck_fall;                // Falling test-clock edge seen
	logic              sel_bsr;                 // Boundary register selected
	logic              sel_id;                  // Identification register selected
	logic              ser_bit;                 // Bit to present at next fall
	logic              ext_test;                // External test in effect
	logic              samp_z;                  // Sample-Z in effect

	// Elaboration stops if the code would break the start bit
	if (ID_VALUE[0] != 1'b1)
	begin
		$error("bst_tap: identification code bit 0 must be one");
	end

	// All three pins pass the same two stages, so they stay aligned to each other
	bst_sync #(.W(3)) u_pin_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({tck, tms, tdi}),
		.q      (pin_s)
	);

	// Ring levels come from other domains; captured only at a test-clock edge
	bst_sync #(.W(RING_W)) u_ring_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      (ring_in),
		.q      (ring_s)
	);

	assign tck_s    = pin_s[2];
	assign tms_s    = pin_s[1];
	assign tdi_s    = pin_s[0];
	assign tck_rise = tck_s & ~st_ff.tck_prev;
	assign tck_fall = ~tck_s & st_ff.tck_prev;

	// Data register selection; reserved codes fall back to bypass
	assign sel_bsr = (st_ff.ir_cur == INS_EXT_TEST) || (st_ff.ir_cur == INS_SAMPLE_Z)
		|| (st_ff.ir_cur == INS_SAMPLE);
	assign sel_id  = (st_ff.ir_cur == INS_ID_READ);

	// Next-state and register logic
	always_comb
	begin
		nxt_st          = st_ff;
		nxt_st.tck_prev = tck_s;
		ser_bit         = st_ff.byp;
		// Bit presented at the fall is the low end of the path in use
		if (st_ff.state == ST_SHIFT_IR)
			ser_bit = st_ff.ir_sh[0];
		else if (sel_bsr)
			ser_bit = st_ff.bsr_sh[0];
		else if (sel_id)
			ser_bit = st_ff.id_sh[0];
		if (tck_rise)
		begin
			// Run of ones watched by the reset check; saturates to avoid wrapping
			if (!tms_s)
				nxt_st.ones_cnt = 3'h0;
			else if (st_ff.ones_cnt != 3'h7)
				nxt_st.ones_cnt = st_ff.ones_cnt + 3'h1;
			// Register actions for the state being left
			case (st_ff.state)
				ST_RESET:
				begin
					nxt_st.ir_sh  = IR_RESET_VAL;
					nxt_st.ir_cur = IR_RESET_VAL;
				end
				ST_CAP_IR:
					nxt_st.ir_sh = IR_RESET_VAL;
				ST_SHIFT_IR:
					nxt_st.ir_sh = {tdi_s, st_ff.ir_sh[IR_W-1:1]};
				ST_UPD_IR:
					nxt_st.ir_cur = st_ff.ir_sh;
				ST_CAP_DR:
				begin
					if (sel_bsr)
						nxt_st.bsr_sh = {INT_CELL_CAP, ring_s};
					else if (sel_id)
						nxt_st.id_sh = ID_VALUE;
					else
						nxt_st.byp = BYP_CAPTURE;
				end
				ST_SHIFT_DR:
				begin
					// Serial input enters at the top and leaves at bit 0
					if (sel_bsr)
						nxt_st.bsr_sh = {tdi_s, st_ff.bsr_sh[BSR_W-1:1]};
					else if (sel_id)
						nxt_st.id_sh = {tdi_s, st_ff.id_sh[ID_W-1:1]};
					else
						nxt_st.byp = tdi_s;
				end
				ST_UPD_DR:
				begin
					// Only boundary instructions move the update stage
					if (sel_bsr)
						nxt_st.bsr_upd = st_ff.bsr_sh;
				end
				default:
					nxt_st.byp = st_ff.byp; // No register action
			endcase
			// Controller transitions chosen by mode-select
			case (st_ff.state)
				ST_RESET:    nxt_st.state = tms_s ? ST_RESET : ST_IDLE;
				ST_IDLE:     nxt_st.state = tms_s ? ST_SEL_DR : ST_IDLE;
				ST_SEL_DR:   nxt_st.state = tms_s ? ST_SEL_IR : ST_CAP_DR;
				ST_CAP_DR:   nxt_st.state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
				ST_SHIFT_DR: nxt_st.state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
				ST_EXIT1_DR: nxt_st.state = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
				ST_PAUSE_DR: nxt_st.state = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
				ST_EXIT2_DR: nxt_st.state = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
				ST_UPD_DR:   nxt_st.state = tms_s ? ST_SEL_DR : ST_IDLE;
				ST_SEL_IR:   nxt_st.state = tms_s ? ST_RESET : ST_CAP_IR;
				ST_CAP_IR:   nxt_st.state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
				ST_SHIFT_IR: nxt_st.state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
				ST_EXIT1_IR: nxt_st.state = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
				ST_PAUSE_IR: nxt_st.state = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
				ST_EXIT2_IR: nxt_st.state = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
				ST_UPD_IR:   nxt_st.state = tms_s ? ST_SEL_DR : ST_IDLE;
				default:     nxt_st.state = ST_RESET; // Unused codes recover
			endcase
		end
		// Output side changes only at the fall, half a test clock after the shift
		if (tck_fall)
		begin
			nxt_st.tdo_oe = (st_ff.state == ST_SHIFT_IR) || (st_ff.state == ST_SHIFT_DR);
			nxt_st.tdo    = ser_bit;
		end
	end

	// State register; power-up lands in the reset state
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_ff         <= '0;
			st_ff.state   <= ST_RESET;
			st_ff.ir_sh   <= IR_RESET_VAL;
			st_ff.ir_cur  <= IR_RESET_VAL;
		end
		else
			st_ff <= nxt_st;
	end

	// Pin-facing outputs; other instructions leave memory pins alone
	assign ext_test               = (st_ff.ir_cur == INS_EXT_TEST);
	assign samp_z                 = (st_ff.ir_cur == INS_SAMPLE_Z);
	assign tdo                    = st_ff.tdo;
	assign tdo_oe                 = st_ff.tdo_oe;
	assign ring_out               = st_ff.bsr_upd[RING_W-1:0];
	assign pins_takeover          = ext_test | samp_z;
	assign q_drive_en             = samp_z ? 1'b0 :
		(ext_test ? st_ff.bsr_upd[INT_CELL] : 1'b1);
	assign on_die_termination_dis = ext_test | samp_z;

	a_five_ones_reset: assert property (@(posedge clk) disable iff (!arst_n)
		(st_ff.ones_cnt >= 3'h5) |-> (st_ff.state == ST_RESET))
		else $error("five mode-select ones did not reach reset");

	a_oe_shift_only: assert property (@(posedge clk) disable iff (!arst_n)
		tck_fall |=> (tdo_oe == ($past(st_ff.state) == ST_SHIFT_IR
			|| $past(st_ff.state) == ST_SHIFT_DR)))
		else $error("serial output enable wrong after fall");

	a_tdo_fall_only: assert property (@(posedge clk) disable iff (!arst_n)
		!tck_fall |=> $stable(tdo) && $stable(tdo_oe))
		else $error("serial output changed without a fall");

	a_ir_reset_id: assert property (@(posedge clk) disable iff (!arst_n)
		(st_ff.state == ST_RESET) && tck_rise |=> (st_ff.ir_cur == INS_ID_READ))
		else $error("instruction not identify after reset state");

	a_ir_upd_only: assert property (@(posedge clk) disable iff (!arst_n)
		tck_rise && (st_ff.state != ST_UPD_IR) && (st_ff.state != ST_RESET)
		|=> $stable(st_ff.ir_cur))
		else $error("instruction changed outside update");

	a_id_capture: assert property (@(posedge clk) disable iff (!arst_n)
		tck_rise && (st_ff.state == ST_CAP_DR) && sel_id |=> (st_ff.id_sh == ID_VALUE))
		else $error("identification code not captured");

	a_bypass_zero: assert property (@(posedge clk) disable iff (!arst_n)
		tck_rise && (st_ff.state == ST_CAP_DR) && (st_ff.ir_cur == INS_BYPASS)
		|=> (st_ff.byp == 1'b0))
		else $error("bypass did not capture zero");

	a_int_cell_one: assert property (@(posedge clk) disable iff (!arst_n)
		tck_rise && (st_ff.state == ST_CAP_DR) && sel_bsr |=> st_ff.bsr_sh[INT_CELL])
		else $error("internal cell did not capture one");

	a_upd_dr_only: assert property (@(posedge clk) disable iff (!arst_n)
		tck_rise && (st_ff.state != ST_UPD_DR) |=> $stable(ring_out))
		else $error("output cells changed outside update");

	a_sample_z_off: assert property (@(posedge clk) disable iff (!arst_n)
		(st_ff.ir_cur == INS_SAMPLE_Z) |-> !q_drive_en && on_die_termination_dis)
		else $error("sample-Z left drivers or termination on");

	a_odt_rise_upd: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(on_die_termination_dis) |-> ($past(st_ff.state) == ST_UPD_IR))
		else $error("termination disabled outside instruction update");

endmodule

// ==== tb/boundary_scan_tap_bench.sv ====
// Self-checking bench for the boundary scan test access port.
`timescale 1ns/1ps
module boundary_scan_tap_bench;
	import bst_pkg::*;

	localparam logic [31:0] BENCH_ID = 32'h5A3C_9E01; // Arbitrary code, bit 0 one

	logic               clk;          // 50 MHz bench clock
	logic               arst_n;       // Reset, active low
	logic               tck;          // Test clock from the model
	logic               tms;          // Mode-select from the model
	logic               tdi;          // Serial data from the model
	logic               tdo;          // Serial data out
	logic               tdo_oe;       // Serial driver enable
	logic [RING_W-1:0]  ring_in;      // Random ring levels
	logic [RING_W-1:0]  ring_out;     // Output cell values
	logic               takeover;     // Test logic owns pins
	logic               q_drive_en;   // Read-data drivers on
	logic               odt_dis;      // Termination off
	integer             seed;         // Fixed seed, repeatable run
	int                 fail_count;   // Mismatches
	int                 cmp_count;    // Comparisons

	bst_tap #(.ID_VALUE(BENCH_ID)) dut_u (.clk(clk), .arst_n(arst_n), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out),
		.pins_takeover(takeover), .q_drive_en(q_drive_en), .on_die_termination_dis(odt_dis));

	bst_ctl_model ctl_u (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
		.tdi(tdi));

	// Clock generator
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Flag compare
	task automatic chk_bit(input logic got, input logic exp);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	end
	endtask

	// Vector compare, wide enough for a boundary scan plus overrun
	task automatic chk_vec(input logic [136:0] got, input logic [136:0] exp);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	end
	endtask

	// Path length selected by an instruction; reserved codes act as bypass
	function automatic int dr_len(logic [2:0] c);
	begin
		case (c)
			INS_ID_READ:                         return ID_W;
			INS_EXT_TEST, INS_SAMPLE_Z, INS_SAMPLE: return BSR_W;
			default:                             return 1;
		endcase
	end
	endfunction

	// Captured value first, then the shifted-in bits after one path length
	function automatic logic [136:0] exp_out(logic [2:0] c, logic [136:0] d);
		logic [136:0] cap;
		int           l;
	begin
		l   = dr_len(c);
		cap = (c == INS_ID_READ) ? 137'(BENCH_ID) :
			(l == 1) ? 137'(BYP_CAPTURE) : 137'({INT_CELL_CAP, ring_in});
		return (cap | (d << l)) & ((137'(1) << (l + 8)) - 137'(1));
	end
	endfunction

	// Load an instruction; capture must show the identify code
	task automatic load_ir(input logic [2:0] c);
		logic [136:0] dout;
		logic         ok;
	begin
		ctl_u.scan(1'b1, IR_W, 137'(c), dout, ok);
		chk_vec(dout, 137'(IR_RESET_VAL));
		chk_bit(ok, 1'b1);
	end
	endtask

	// Scan 8 bits past the path, update, then check the pin-side outputs
	task automatic run_dr(input logic [2:0] c);
		logic [136:0] din;
		logic [136:0] dout;
		logic         ok;
		logic         tk;
	begin
		din     = 137'({$random(seed), $random(seed), $random(seed), $random(seed),
			$random(seed)});
		ring_in = {$random(seed), $random(seed), $random(seed), $random(seed)};
		tk      = (c == INS_EXT_TEST) || (c == INS_SAMPLE_Z);
		ctl_u.scan(1'b0, dr_len(c) + 8, din, dout, ok);
		chk_vec(dout, exp_out(c, din));
		chk_bit(ok, 1'b1);
		chk_bit(takeover, tk);
		chk_bit(odt_dis, tk);
		chk_bit(q_drive_en, (c == INS_SAMPLE_Z) ? 1'b0 :
			(c == INS_EXT_TEST) ? din[BSR_W + 7] : 1'b1);
		if (tk)
			chk_vec(137'(ring_out), 137'(din[8 +: RING_W]));
	end
	endtask

	// Counts, verdict, end of run
	task automatic test_done;
	begin
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask

	logic [2:0] code; // Instruction under test, drawn by the bench

	// Main sequence
	initial
	begin
		seed       = 32'h057b703a;
		fail_count = 0;
		cmp_count  = 0;
		arst_n     = 1'b0;
		ring_in    = '0;
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
		chk_bit(tdo_oe, 1'b0);
		chk_bit(takeover, 1'b0);
		chk_bit(q_drive_en, 1'b1);
		chk_bit(odt_dis, 1'b0);
		repeat (4) @(negedge clk);
		ctl_u.to_reset();
		run_dr(INS_ID_READ);
		// Every code once, then random codes; the same drawn code is loaded and scanned
		for (int k = 0; k < 14; k++)
		begin
			code = (k < 8) ? 3'(k) : 3'($random(seed));
			load_ir(code);
			run_dr(code);
		end
		// Five ones must drop an external test back to identify
		load_ir(INS_EXT_TEST);
		chk_bit(takeover, 1'b1);
		ctl_u.to_reset();
		chk_bit(takeover, 1'b0);
		chk_bit(odt_dis, 1'b0);
		// A power-up reset in mid-run must drop a sample-Z as well
		load_ir(INS_SAMPLE_Z);
		chk_bit(q_drive_en, 1'b0);
		arst_n = 1'b0;
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		chk_bit(odt_dis, 1'b0);
		chk_bit(q_drive_en, 1'b1);
		chk_bit(tdo_oe, 1'b0);
		repeat (4) @(negedge clk);
		ctl_u.to_reset();
		run_dr(INS_ID_READ);
		test_done();
	end

	// Watchdog, about eight times the expected run
	initial
	begin
		repeat (80000) @(posedge clk);
		fail_count++;
		test_done();
	end
endmodule

// ==== tb/bst_ctl_model.sv ====
// Test controller model: drives the test clock, mode-select and serial data.
`timescale 1ns/1ps
module bst_ctl_model (
	input  wire logic clk,    // Bench clock, paces the test clock
	input  wire logic tdo,    // Serial data from the device
	input  wire logic tdo_oe, // Device drives serial data
	output logic      tck,    // Test clock, 160 ns period
	output logic      tms,    // Mode-select
	output logic      tdi     // Serial data to the device
);
	// Test clock parked low, as a tester leaves it between frames
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One test clock cycle, 80 ns low and 80 ns high. The output is taken just
	// before the rise, which leaves the device the whole low phase to answer.
	// Mode-select and data get one bench cycle of setup before the rise.
	// A released output has no pull, so it reads as the inverse of the last bit.
	task automatic step(input logic m, input logic d, output logic q, output logic oe);
	begin
		tms = m;
		tdi = d;
		@(negedge clk);
		q   = tdo_oe ? tdo : ~tdo;
		oe  = tdo_oe;
		tck = 1'b1;
		repeat (4) @(negedge clk);
		tck = 1'b0;
		repeat (3) @(negedge clk);
	end
	endtask

	// Five ones from any state, then one step to Idle; data keeps toggling
	task automatic to_reset;
		logic q;
		logic oe;
	begin
		repeat (5) step(1'b1, ~tdi, q, oe);
		step(1'b0, ~tdi, q, oe);
	end
	endtask

	// One IR or DR scan of n bits from Idle back to Idle; oe_ok falls if the
	// driver is seen on in capture or exit-1, or off inside the shift state
	task automatic scan(input logic ir, input int n, input logic [136:0] din,
		output logic [136:0] dout, output logic oe_ok);
		logic q;
		logic oe;
	begin
		dout  = '0;
		oe_ok = 1'b1;
		step(1'b1, ~tdi, q, oe);         // To select-DR
		if (ir)
			step(1'b1, ~tdi, q, oe);     // On to select-IR
		step(1'b0, ~tdi, q, oe);         // To capture
		step(1'b0, ~tdi, q, oe);         // To shift, sampled in capture
		oe_ok = oe_ok & ~oe;
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q, oe);
			dout[i] = q;
			oe_ok   = oe_ok & oe;
		end
		step(1'b1, ~tdi, q, oe);         // To update, sampled in exit
		oe_ok = oe_ok & ~oe;
		step(1'b0, ~tdi, q, oe);         // Back to Idle
	end
	endtask
endmodule
